// ===== dsr_status_bank.v
`timescale 1ns/10ps
`include "dsr_map.vh"
// -----------------------------------------------------------------
// Drive status register bank
// -----------------------------------------------------------------
// Function
// R1 - Status bits 0..3 show target reached, drag error, reverse jog key, forward jog key.
// R2 - Status bits 4..7 show motor power, aborted run, running, over-temperature.
// R3 - Status bits 8..11 show against-loop motion, general error, blocked, manual displacement.
// R4 - Status bits 12..15 show bad target, power was lost, positive and negative limits.
// R5 - Position reads as a signed 32-bit count of hundredths of a millimetre.
// R6 - A position write re-references the present shaft position without moving.
// R7 - Peak torque of the latest run is held, start and braking phases excluded.
// R8 - Logic supply voltage reads as unsigned 16-bit in 0.1 V steps.
// R9 - Motor supply voltage reads as unsigned 16-bit in 0.1 V steps.
// R10 - Temperature reads as signed 16-bit whole degrees, read-only.
// R11 - Manufacture date reads as one integer, year pair high and week pair low.
// R12 - Reserved slots between temperature and date read as zero.
// R13 - 32-bit writes go high word first; the value changes only on the low-word write.
// R14 - Speed reads as signed 16-bit rpm, negative toward smaller positions.
module dsr_status_bank #(
	parameter [15:0] SERIAL_NUMBER = 16'h0001,  // Arbitrary default
	parameter [15:0] MFG_YEAR_WEEK = 16'h0000   // Integer YYWW, arbitrary default
) (
	input  wire        clk,
	input  wire        rst_n,
	// Holding register access port
	input  wire        hreg_rd,
	input  wire        hreg_wr,
	input  wire [7:0]  hreg_addr,
	input  wire [15:0] hreg_wdata,
	output reg  [15:0] hreg_rdata,
	output reg         hreg_ack,
	output reg         hreg_reject,
	// Drive state, same clock domain
	input  wire [15:0] status_flags,
	input  wire [15:0] speed_rpm,
	input  wire [31:0] encoder_pos,
	input  wire [15:0] torque_cnm,
	input  wire [1:0]  run_phase,
	input  wire [15:0] temp_deg,
	// Analog monitor words from outside the clock domain
	input  wire [15:0] logic_volt_raw,
	input  wire [15:0] motor_volt_raw,
	// Position offset loaded by a referencing write
	output reg  [31:0] pos_offset,
	output reg         reref_pulse
);
	// -----------------------------------------------------------------
	// Input capture
	// -----------------------------------------------------------------
	wire [15:0] logic_volt;
	wire [15:0] motor_volt;
	wire [15:0] peak_torque;
	reg  [15:0] pos_hi_stage;
	reg         hi_pending;
	reg  [31:0] next_offset;
	wire [31:0] cur_pos;
	reg  [15:0] next_rdata;
	reg         next_reject;
	wire        rsvd_hit;

	// Voltages come from a converter on another clock
	dsr_sync #(
		.WIDTH (16)
	) u_sync_logic (
		.clk   (clk),
		.rst_n (rst_n),
		.d     (logic_volt_raw),
		.q     (logic_volt)
	);

	dsr_sync #(
		.WIDTH (16)
	) u_sync_motor (
		.clk   (clk),
		.rst_n (rst_n),
		.d     (motor_volt_raw),
		.q     (motor_volt)
	);

	dsr_peak u_peak (
		.clk    (clk),
		.rst_n  (rst_n),
		.phase  (run_phase),
		.torque (torque_cnm),
		.peak   (peak_torque)
	);

	// -----------------------------------------------------------------
	// Position referencing
	// -----------------------------------------------------------------
	// Reported position is encoder plus offset, in hundredths of a mm
	assign cur_pos = encoder_pos + pos_offset;                 // [R5]

	// Offset chosen so the present position equals the written value
	always @* begin
		next_offset = {pos_hi_stage, hreg_wdata} - encoder_pos;  // [R6]
	end

	// High word staged; any other write between halves cancels it
	always @(posedge clk) begin
		if (!rst_n) begin
			pos_hi_stage <= `DSR_RST_WORD;
			hi_pending   <= 1'b0;
			pos_offset   <= `DSR_RST_POS;
			reref_pulse  <= 1'b0;
		end else begin
			reref_pulse <= 1'b0;
			if (hreg_wr) begin
				if (hreg_addr == `DSR_IDX_POS_HI) begin
					pos_hi_stage <= hreg_wdata;                 // [R13]
					hi_pending   <= 1'b1;
				end else begin
					hi_pending <= 1'b0;
					if (hreg_addr == `DSR_IDX_POS_LO && hi_pending) begin
						pos_offset  <= next_offset;             // [R13] [R6]
						reref_pulse <= 1'b1;
					end
				end
			end
		end
	end

	// -----------------------------------------------------------------
	// Read mux
	// -----------------------------------------------------------------
	assign rsvd_hit = (hreg_addr >= `DSR_IDX_RSV_FIRST) && (hreg_addr <= `DSR_IDX_RSV_LAST);

	// Decode; reserved reads zero, unknown addresses are refused
	always @* begin
		next_rdata  = `DSR_RST_WORD;
		next_reject = 1'b0;
		case (hreg_addr)
			`DSR_IDX_STATUS: next_rdata = status_flags;        // [R1] [R2] [R3] [R4]
			`DSR_IDX_SPEED:  next_rdata = speed_rpm;           // [R14]
			`DSR_IDX_POS_HI: next_rdata = cur_pos[31:16];      // [R5]
			`DSR_IDX_POS_LO: next_rdata = cur_pos[15:0];       // [R5]
			`DSR_IDX_TORQUE: next_rdata = torque_cnm;
			`DSR_IDX_PEAK:   next_rdata = peak_torque;         // [R7]
			`DSR_IDX_ULOGIC: next_rdata = logic_volt;          // [R8]
			`DSR_IDX_UMOTOR: next_rdata = motor_volt;          // [R9]
			`DSR_IDX_TEMP:   next_rdata = temp_deg;            // [R10]
			`DSR_IDX_DATE:   next_rdata = MFG_YEAR_WEEK;       // [R11]
			`DSR_IDX_SERIAL: next_rdata = SERIAL_NUMBER;
			default: begin
				next_rdata  = `DSR_RST_WORD;                   // [R12]
				next_reject = !rsvd_hit;
			end
		endcase
	end

	// Answer one cycle after request; writes to read-only words are ignored
	always @(posedge clk) begin
		if (!rst_n) begin
			hreg_rdata  <= `DSR_RST_WORD;
			hreg_ack    <= 1'b0;
			hreg_reject <= 1'b0;
		end else begin
			hreg_ack    <= hreg_rd | hreg_wr;
			hreg_reject <= (hreg_rd | hreg_wr) & next_reject;
			if (hreg_rd)
				hreg_rdata <= next_rdata;                      // [R10]
			if (hreg_wr && hreg_addr == `DSR_IDX_POS_LO && !hi_pending)
				hreg_reject <= 1'b1;                           // [R13]
		end
	end
endmodule

// ===== dsr_map.vh
`ifndef DSR_MAP_VH
`define DSR_MAP_VH
// -----------------------------------------------------------------
// Register indices (one holding_reg each)
// -----------------------------------------------------------------
`define DSR_IDX_STATUS      8'h00
`define DSR_IDX_SPEED       8'h01
`define DSR_IDX_POS_HI      8'h02
`define DSR_IDX_POS_LO      8'h03
`define DSR_IDX_TORQUE      8'h04
`define DSR_IDX_PEAK        8'h05
`define DSR_IDX_ULOGIC      8'h06
`define DSR_IDX_UMOTOR      8'h07
`define DSR_IDX_TEMP        8'h08
`define DSR_IDX_RSV_FIRST   8'h09
`define DSR_IDX_RSV_LAST    8'h0b
`define DSR_IDX_DATE        8'h0c
`define DSR_IDX_SERIAL      8'h0d
// -----------------------------------------------------------------
// Status word bit positions
// -----------------------------------------------------------------
`define DSR_BIT_TARGET_REACHED  0
`define DSR_BIT_DRAG_ERROR      1
`define DSR_BIT_JOG_REV         2
`define DSR_BIT_JOG_FWD         3
`define DSR_BIT_MOTOR_POWER     4
`define DSR_BIT_RUN_ABORTED     5
`define DSR_BIT_RUNNING         6
`define DSR_BIT_OVER_TEMP       7
`define DSR_BIT_AGAINST_LOOP    8
`define DSR_BIT_GEN_ERROR       9
`define DSR_BIT_BLOCKED         10
`define DSR_BIT_MANUAL_MOVE     11
`define DSR_BIT_BAD_TARGET      12
`define DSR_BIT_POWER_WAS_LOST  13
`define DSR_BIT_LIMIT_POS       14
`define DSR_BIT_LIMIT_NEG       15
// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define DSR_RST_WORD        16'h0000
`define DSR_RST_POS         32'h0000_0000
// Run phase codes
`define DSR_PH_IDLE         2'h0
`define DSR_PH_START        2'h1
`define DSR_PH_CRUISE       2'h2
`define DSR_PH_BRAKE        2'h3
`endif

// ===== dsr_sync.v
`timescale 1ns/10ps
// Three-stage synchroniser; output changes once stages two and three agree
module dsr_sync #(
	parameter WIDTH = 16
) (
	input  wire             clk,
	input  wire             rst_n,
	input  wire [WIDTH-1:0] d,
	output reg  [WIDTH-1:0] q
);
	reg [WIDTH-1:0] s1;
	reg [WIDTH-1:0] s2;
	reg [WIDTH-1:0] s3;

	// Chain; s1 is read only by s2
	always @(posedge clk) begin
		if (!rst_n) begin
			s1 <= {WIDTH{1'b0}};
			s2 <= {WIDTH{1'b0}};
			s3 <= {WIDTH{1'b0}};
		end else begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// Whole-word agreement; a word caught mid-change is held back, never torn
	always @(posedge clk) begin
		if (!rst_n)
			q <= {WIDTH{1'b0}};
		else if (s2 == s3)
			q <= s3;
	end
endmodule

// ===== dsr_peak.v
`timescale 1ns/10ps
`include "dsr_map.vh"
// Peak torque tracker for one run; ignores start and braking phases
module dsr_peak (
	input  wire        clk,
	input  wire        rst_n,
	input  wire [1:0]  phase,
	input  wire [15:0] torque,
	output reg  [15:0] peak
);
	reg [1:0] last_phase;

	// New run clears the peak; only cruise phase samples it
	always @(posedge clk) begin
		if (!rst_n) begin
			peak       <= `DSR_RST_WORD;
			last_phase <= `DSR_PH_IDLE;
		end else begin
			last_phase <= phase;
			if (phase == `DSR_PH_START && last_phase == `DSR_PH_IDLE)
				peak <= `DSR_RST_WORD;                     // [R7]
			else if (phase == `DSR_PH_CRUISE && torque > peak)
				peak <= torque;                            // [R7]
		end
	end
endmodule

// ===== dsr_status_bank_monitor.sv
`timescale 1ns/10ps
// ----------------------------------------
// Port checker for the status bank
// ----------------------------------------
module dsr_status_bank_monitor (
	input        clk,
	input        rst_n,
	input        hreg_rd,
	input        hreg_wr,
	input [7:0]  hreg_addr,
	input [15:0] hreg_rdata,
	input        hreg_ack,
	input        hreg_reject,
	input [15:0] status_flags,
	input [15:0] speed_rpm,
	input [31:0] encoder_pos,
	input [15:0] temp_deg,
	input [31:0] pos_offset,
	input        reref_pulse
);
	// Position as the master should see it
	wire [31:0] pos_sum = encoder_pos + pos_offset;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Read data is the source sampled at the request edge
	a_status_word: assert property (
		hreg_rd && hreg_addr == 8'h00 |=> hreg_rdata == $past(status_flags)) else $error("status");
	a_speed_read: assert property (
		hreg_rd && hreg_addr == 8'h01 |=> hreg_rdata == $past(speed_rpm)) else $error("speed");
	a_temp_read: assert property (
		hreg_rd && hreg_addr == 8'h08 |=> hreg_rdata == $past(temp_deg)) else $error("temp");
	a_reserved_zero: assert property (
		hreg_rd && hreg_addr >= 8'h09 && hreg_addr <= 8'h0b |=> hreg_rdata == 16'h0000
		&& !hreg_reject) else $error("reserved");
	a_pos_high: assert property (
		hreg_rd && hreg_addr == 8'h02 |=> hreg_rdata == $past(pos_sum[31:16])) else $error("pos hi");
	a_pos_low: assert property (
		hreg_rd && hreg_addr == 8'h03 |=> hreg_rdata == $past(pos_sum[15:0])) else $error("pos lo");
	// Offset must never drift between referencing writes
	a_offset_held: assert property (
		!reref_pulse |-> $stable(pos_offset)) else $error("offset moved");
	a_reref_cause: assert property (
		reref_pulse |-> hreg_ack && !hreg_reject && $past(hreg_wr) && $past(hreg_addr) == 8'h03)
		else $error("reref cause");
endmodule
bind dsr_status_bank dsr_status_bank_monitor mon_u (.clk(clk), .rst_n(rst_n), .hreg_rd(hreg_rd),
	.hreg_wr(hreg_wr), .hreg_addr(hreg_addr), .hreg_rdata(hreg_rdata), .hreg_ack(hreg_ack),
	.hreg_reject(hreg_reject), .status_flags(status_flags), .speed_rpm(speed_rpm),
	.encoder_pos(encoder_pos), .temp_deg(temp_deg), .pos_offset(pos_offset),
	.reref_pulse(reref_pulse));

// ===== dsr_master.sv
`timescale 1ns/10ps
// ----------------------------------------
// Bus master model for holding registers
// ----------------------------------------
module dsr_master (
	input             clk,
	input [15:0]      hreg_rdata,
	input             hreg_ack,
	input             hreg_reject,
	output reg        hreg_rd = 1'b0,
	output reg        hreg_wr = 1'b0,
	output reg [7:0]  hreg_addr = 8'h00,
	output reg [15:0] hreg_wdata = 16'h0000
);
	// One-cycle request; idle lines show inverted data so stale values cannot pass
	task xfer(input w, input [7:0] a, input [15:0] d, output [17:0] r);
		@(posedge clk);
		hreg_rd <= !w;
		hreg_wr <= w;
		hreg_addr <= a;
		hreg_wdata <= d;
		@(posedge clk);
		hreg_rd <= 1'b0;
		hreg_wr <= 1'b0;
		hreg_addr <= ~a;
		hreg_wdata <= ~d;
		#1;
		r = {hreg_ack, hreg_reject, hreg_rdata};
	endtask
endmodule

// ===== dsr_status_bank_tb.sv
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
	$display("Error t=%0t got %h exp %h", $time, g, e); end end
// ----------------------------------------
// Status bank testbench
// ----------------------------------------
module dsr_status_bank_tb;
	reg         clk, rst_n;
	reg  [15:0] status_flags, speed_rpm, torque_cnm, temp_deg, logic_volt_raw, motor_volt_raw;
	reg  [31:0] encoder_pos;
	reg  [1:0]  run_phase;
	wire        hreg_rd, hreg_wr, hreg_ack, hreg_reject, reref_pulse;
	wire [7:0]  hreg_addr;
	wire [15:0] hreg_wdata, hreg_rdata;
	wire [31:0] pos_offset;
	reg  [17:0] r;
	int         n_fail = 0, checks = 0, i;
	dsr_status_bank #(.SERIAL_NUMBER(16'h0042), .MFG_YEAR_WEEK(16'h2431)) dut_u (.clk(clk),
		.rst_n(rst_n), .hreg_rd(hreg_rd), .hreg_wr(hreg_wr), .hreg_addr(hreg_addr),
		.hreg_wdata(hreg_wdata), .hreg_rdata(hreg_rdata), .hreg_ack(hreg_ack),
		.hreg_reject(hreg_reject), .status_flags(status_flags), .speed_rpm(speed_rpm),
		.encoder_pos(encoder_pos), .torque_cnm(torque_cnm), .run_phase(run_phase),
		.temp_deg(temp_deg), .logic_volt_raw(logic_volt_raw), .motor_volt_raw(motor_volt_raw),
		.pos_offset(pos_offset), .reref_pulse(reref_pulse));
	dsr_master m_u (.clk(clk), .hreg_rdata(hreg_rdata), .hreg_ack(hreg_ack),
		.hreg_reject(hreg_reject), .hreg_rd(hreg_rd), .hreg_wr(hreg_wr), .hreg_addr(hreg_addr),
		.hreg_wdata(hreg_wdata));
	// Read expects an ack without reject
	task rchk(input [7:0] a, input [15:0] e);
		m_u.xfer(1'b0, a, 16'h0000, r);
		`CHK(r, {2'b10, e})
	endtask
	task wchk(input [7:0] a, input [15:0] d, input rj);
		m_u.xfer(1'b1, a, d, r);
		`CHK(r[17:16], {1'b1, rj})
	endtask
	// Hold a run phase long enough for the tracker to see it
	task phase(input [1:0] p, input [15:0] t);
		@(posedge clk);
		run_phase <= p;
		torque_cnm <= t;
		repeat (3) @(posedge clk);
	endtask
	task summarize;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Watchdog, far beyond the roughly 150 cycles the tests need
	initial begin
		repeat (3000) @(posedge clk);
		n_fail++;
		summarize;
	end
	initial begin
		{rst_n, status_flags, speed_rpm, torque_cnm, temp_deg} = 0;
		{logic_volt_raw, motor_volt_raw, encoder_pos, run_phase} = 0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge clk);
			status_flags <= 16'h0001 << i;
			rchk(8'h00, 16'h0001 << i);
		end
		$display("test status done");
		@(posedge clk);
		speed_rpm <= 16'h8123;
		temp_deg <= 16'hfff6;
		logic_volt_raw <= 16'h00f0;
		motor_volt_raw <= 16'h01e5;
		repeat (8) @(posedge clk);
		rchk(8'h01, 16'h8123);
		rchk(8'h06, 16'h00f0);
		rchk(8'h07, 16'h01e5);
		wchk(8'h08, 16'h1234, 1'b0);
		rchk(8'h08, 16'hfff6);
		for (i = 9; i < 12; i++) rchk(i[7:0], 16'h0000);
		rchk(8'h0c, 16'h2431);
		$display("test values done");
		@(posedge clk);
		encoder_pos <= 32'h0001_0002;
		rchk(8'h02, 16'h0001);
		rchk(8'h03, 16'h0002);
		wchk(8'h02, 16'h1234, 1'b0);
		wchk(8'h03, 16'h5678, 1'b0);
		rchk(8'h02, 16'h1234);
		@(posedge clk);
		encoder_pos <= 32'h0001_0007;
		rchk(8'h03, 16'h567d);
		wchk(8'h03, 16'h0000, 1'b1);
		wchk(8'h02, 16'h0000, 1'b0);
		wchk(8'h01, 16'h0000, 1'b0);
		wchk(8'h03, 16'h0000, 1'b1);
		rchk(8'h02, 16'h1234);
		$display("test position done");
		phase(2'h1, 16'h0100);
		phase(2'h2, 16'h0050);
		phase(2'h2, 16'h0080);
		phase(2'h3, 16'h0200);
		phase(2'h0, 16'h0000);
		rchk(8'h05, 16'h0080);
		phase(2'h1, 16'h0090);
		phase(2'h2, 16'h0030);
		phase(2'h0, 16'h0000);
		rchk(8'h05, 16'h0030);
		$display("test peak done");
		// Reset between runs clears peak, offset and any staged high word
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rchk(8'h05, 16'h0000);
		rchk(8'h02, 16'h0001);
		rchk(8'h03, 16'h0007);
		wchk(8'h03, 16'h0000, 1'b1);
		$display("test reset done");
		summarize;
	end
endmodule
